// file: rtl/dvspc_defs.svh
`ifndef DVSPC_DEFS_SVH
`define DVSPC_DEFS_SVH

// host port register offsets
`define DVSPC_OFS_RX_CFG 8'h00
`define DVSPC_OFS_FILT_A 8'h04
`define DVSPC_OFS_FILT_B 8'h08
`define DVSPC_OFS_STATUS 8'h0c
`define DVSPC_OFS_TX_CFG 8'h10
`define DVSPC_OFS_TX_H0 8'h14
`define DVSPC_OFS_TX_H1 8'h18
`define DVSPC_OFS_TX_H2 8'h1c
`define DVSPC_OFS_TX_H3 8'h20
`define DVSPC_OFS_TX_H4 8'h24
`define DVSPC_OFS_ACC0 8'h28
`define DVSPC_OFS_ACC1 8'h2c

// rx config fields
`define DVSPC_RXC_EN 0
`define DVSPC_RXC_MODE_LO 1
`define DVSPC_RXC_STRIP_ISO 3
`define DVSPC_RXC_STRIP_CIPA 4
`define DVSPC_RXC_STRIP_CIPB 5
`define DVSPC_RXC_TOKEN_INS 6
`define DVSPC_RXC_FILT_EN 7
`define DVSPC_RXC_RELEASE 8
`define DVSPC_RXC_FLUSH 9

// tx config fields
`define DVSPC_TXC_HDR_INS 0
`define DVSPC_TXC_DIF_INS 1
`define DVSPC_TXC_DLY_EN 2
`define DVSPC_TXC_DLY_SEL_LO 3
`define DVSPC_TXC_TYPE_LO 5

// reset values
`define DVSPC_RST_RX_CFG 32'h0000_0000
`define DVSPC_RST_TX_CFG 32'h0000_0000
`define DVSPC_RST_TX_H0 32'h0008_40a0
`define DVSPC_RST_TX_H1 32'h0078_0000
`define DVSPC_RST_TX_H2 32'h8000_ffff
`define DVSPC_RST_TX_H3 32'h0000_0000
`define DVSPC_RST_TX_H4 32'h0000_0000

// dv stream constants
`define DVSPC_SEQ_PKTS 5'h19
`define DVSPC_SYT_NONE 16'hffff
`define DVSPC_TYPE_DV 2'h1
`define DVSPC_DLY_STEP 3'h4

`endif

// file: rtl/dvspc_pkg.sv
package dvspc_pkg;
  typedef enum logic [1:0] {
    DVSPC_RX_HDR = 2'b00,
    DVSPC_RX_EMIT = 2'b01,
    DVSPC_RX_BODY = 2'b10,
    DVSPC_RX_SKIP = 2'b11
  } dvspc_rx_state_t;

  typedef enum logic [1:0] {
    DVSPC_TX_IDLE = 2'b00,
    DVSPC_TX_HDR = 2'b01,
    DVSPC_TX_BODY = 2'b10
  } dvspc_tx_state_t;

  typedef enum logic [1:0] {
    DVSPC_MODE_DATA = 2'b00,
    DVSPC_MODE_HONLY = 2'b01,
    DVSPC_MODE_SPLIT = 2'b10
  } dvspc_rx_mode_t;
endpackage

// file: rtl/dvspc_fifo.sv
module dvspc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [$clog2(DEPTH+1)-1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = cnt_q != DEPTH[$clog2(DEPTH+1)-1:0];
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign count = cnt_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers wrap by hand so depth need not be a power of two
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{($clog2(DEPTH+1)-1){1'b0}}, push}
        - {{($clog2(DEPTH+1)-1){1'b0}}, pop};
    end
  end
endmodule

// file: rtl/dvspc_top.sv
// Contract
// - cell available on first stored packet
// - frame output on packet with valid stamp
// - interrupt on sequence break or count not 25
// - after break discard until start of frame
// - headers-only captures block zero packets, all channels
// - six quadlets: token, iso, cip0, cip1, h0 pair
// - headers-only overflow stops capture until flush
// - initial delay holds first tx packet for threshold
// - split mode: payload high buffer, headers low
// - header buffer gets headers, stops when full
// - token insert bit ignored, token appended after headers in split mode
// - data available while one quadlet pending
// - strip iso, cip0, cip1 per bit; h0 kept
// - optional masked match filter on incoming packets
// - insert headers per stream type, h0 optional
// - tx header quadlets reset to documented defaults
// - no dv data before start of frame
`include "dvspc_defs.svh"
module dvspc_top import dvspc_pkg::*; #(
  parameter int FIFO_DEPTH = 16,
  parameter int HBUF_DEPTH = 24
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata_q,
  input wire logic rx_valid,
  input wire logic [31:0] rx_data,
  input wire logic rx_last,
  input wire logic [31:0] rx_token,
  output logic rx_ready_q,
  output logic stream_break_irq_q,
  input wire logic stream_port_write_enable,
  input wire logic frame_in,
  output logic [31:0] stream_data_port_q,
  output logic stream_port_data_available_q,
  output logic cell_available_q,
  output logic frame_out_q,
  output logic tx_valid_q,
  output logic [31:0] tx_data_q,
  output logic tx_last_q,
  input wire logic tx_ready
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int HW = $clog2(HBUF_DEPTH + 1);
  localparam int HA = $clog2(HBUF_DEPTH);

  logic [31:0] rx_cfg_q;
  logic [31:0] filt_a_q;
  logic [31:0] filt_b_q;
  logic [31:0] tx_cfg_q;
  logic [31:0] txh_q [5];
  logic wr_rx_cfg;
  logic wr_tx_cfg;
  logic wr_acc0;
  logic wr_acc1;
  logic rd_acc0;
  dvspc_rx_mode_t mode;
  logic rx_en;
  logic release_mode;

  assign wr_rx_cfg = host_wr && host_addr == `DVSPC_OFS_RX_CFG;
  assign wr_tx_cfg = host_wr && host_addr == `DVSPC_OFS_TX_CFG;
  assign wr_acc0 = host_wr && host_addr == `DVSPC_OFS_ACC0;
  assign wr_acc1 = host_wr && host_addr == `DVSPC_OFS_ACC1;
  assign rd_acc0 = host_rd && host_addr == `DVSPC_OFS_ACC0;
  assign mode = dvspc_rx_mode_t'(rx_cfg_q[`DVSPC_RXC_MODE_LO +: 2]);
  assign rx_en = rx_cfg_q[`DVSPC_RXC_EN];
  assign release_mode = rx_cfg_q[`DVSPC_RXC_RELEASE];

  // flush bit is a strobe and never stored
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rx_cfg_q <= `DVSPC_RST_RX_CFG;
      filt_a_q <= '0;
      filt_b_q <= '0;
      tx_cfg_q <= `DVSPC_RST_TX_CFG;
      txh_q[0] <= `DVSPC_RST_TX_H0;
      txh_q[1] <= `DVSPC_RST_TX_H1;
      txh_q[2] <= `DVSPC_RST_TX_H2;
      txh_q[3] <= `DVSPC_RST_TX_H3;
      txh_q[4] <= `DVSPC_RST_TX_H4;
    end else if (wr_rx_cfg) begin
      rx_cfg_q <= host_wdata & ~(32'h0000_0001 << `DVSPC_RXC_FLUSH);
    end else if (host_wr && host_addr == `DVSPC_OFS_FILT_A) begin
      filt_a_q <= host_wdata;
    end else if (host_wr && host_addr == `DVSPC_OFS_FILT_B) begin
      filt_b_q <= host_wdata;
    end else if (wr_tx_cfg) begin
      tx_cfg_q <= host_wdata;
    end else if (host_wr && host_addr == `DVSPC_OFS_TX_H0) begin
      txh_q[0] <= host_wdata;
    end else if (host_wr && host_addr == `DVSPC_OFS_TX_H1) begin
      txh_q[1] <= host_wdata;
    end else if (host_wr && host_addr == `DVSPC_OFS_TX_H2) begin
      txh_q[2] <= host_wdata;
    end else if (host_wr && host_addr == `DVSPC_OFS_TX_H3) begin
      txh_q[3] <= host_wdata;
    end else if (host_wr && host_addr == `DVSPC_OFS_TX_H4) begin
      txh_q[4] <= host_wdata;
    end
  end

  // ---------------- receive ----------------
  dvspc_rx_state_t rx_state_q;
  dvspc_rx_state_t rx_state_d;
  logic [31:0] hq_q [5];
  logic [31:0] tok_q;
  logic [2:0] idx_q;
  logic [2:0] e_q;
  logic keep_q;
  logic hcap_q;
  logic end_seen_q;
  logic started_q;
  logic dropping_q;
  logic [3:0] last_seq_q;
  logic [4:0] pkt_cnt_q;
  logic rx_take;
  logic decide;
  logic filt_ok;
  logic sof;
  logic seq_new;
  logic brk;
  logic keep;
  logic hdr_pkt;
  logic [5:0] strip;
  logic emit_data;
  logic emit_stall;
  logic [31:0] emit_word;
  logic [31:0] hword;
  logic dq_push;
  logic [31:0] dq_in;
  logic dq_in_ready;
  logic dq_out_valid;
  logic dq_pop;
  logic [31:0] dq_out;
  logic [CW-1:0] dq_cnt;
  logic [CW-1:0] dq_cnt_next;

  assign rx_take = rx_valid && rx_ready_q;
  assign decide = rx_state_q == DVSPC_RX_HDR && rx_take && idx_q == 3'd4
    && !rx_last;
  assign filt_ok = !rx_cfg_q[`DVSPC_RXC_FILT_EN]
    || ((hq_q[0] ^ filt_a_q) & ~filt_b_q) == '0;
  assign hdr_pkt = hq_q[3][31:29] == 3'd0 && hq_q[3][15:8] == 8'h00;
  assign sof = hdr_pkt && hq_q[3][23:20] == 4'h0;
  assign seq_new = hq_q[3][23:20] != last_seq_q;
  assign brk = started_q && seq_new && (pkt_cnt_q != `DVSPC_SEQ_PKTS
    || (hq_q[3][23:20] != last_seq_q + 4'h1 && !sof));
  // a packet is kept from a frame start on, unless a break cut it
  assign keep = filt_ok && (sof || (started_q && !brk && !dropping_q));

  // stripping applies to the three link headers only
  assign strip = {3'b000, rx_cfg_q[`DVSPC_RXC_STRIP_CIPB],
    rx_cfg_q[`DVSPC_RXC_STRIP_CIPA], rx_cfg_q[`DVSPC_RXC_STRIP_ISO]};
  assign emit_word = hq_q[e_q < 3'd5 ? e_q : 3'd0];
  assign emit_data = rx_state_q == DVSPC_RX_EMIT && keep_q && e_q < 3'd5
    && !strip[e_q] && mode != DVSPC_MODE_HONLY;
  assign emit_stall = emit_data && !dq_in_ready;
  // headers-only puts the token first, split mode puts it last
  assign hword = mode == DVSPC_MODE_HONLY
    ? (e_q == 3'd0 ? tok_q : hq_q[e_q - 3'd1])
    : (e_q == 3'd5 ? tok_q : emit_word);
  assign dq_push = emit_data || (rx_state_q == DVSPC_RX_BODY && rx_take);
  assign dq_in = rx_state_q == DVSPC_RX_BODY ? rx_data : emit_word;
  assign dq_cnt_next = dq_cnt + CW'(dq_push && dq_in_ready) - CW'(dq_pop);

  always_comb begin
    rx_state_d = rx_state_q;
    case (rx_state_q)
      DVSPC_RX_HDR: begin
        if (decide) begin
          rx_state_d = DVSPC_RX_EMIT;
        end
      end
      DVSPC_RX_EMIT: begin
        if (e_q == 3'd5 && !emit_stall) begin
          if (end_seen_q) begin
            rx_state_d = DVSPC_RX_HDR;
          end else if (keep_q && mode != DVSPC_MODE_HONLY) begin
            rx_state_d = DVSPC_RX_BODY;
          end else begin
            rx_state_d = DVSPC_RX_SKIP;
          end
        end
      end
      DVSPC_RX_BODY, DVSPC_RX_SKIP: begin
        if (rx_take && rx_last) begin
          rx_state_d = DVSPC_RX_HDR;
        end
      end
      default: rx_state_d = DVSPC_RX_HDR;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rx_state_q <= DVSPC_RX_HDR;
      rx_ready_q <= 1'b0;
      idx_q <= '0;
      e_q <= '0;
      end_seen_q <= 1'b0;
    end else begin
      rx_state_q <= rx_state_d;
      // link stalls while held headers drain and when the fifo nears full
      rx_ready_q <= rx_state_d == DVSPC_RX_HDR
        || rx_state_d == DVSPC_RX_SKIP
        || (rx_state_d == DVSPC_RX_BODY
        && dq_cnt_next < CW'(FIFO_DEPTH - 1));
      if (rx_state_q == DVSPC_RX_HDR && rx_take) begin
        idx_q <= (rx_last || idx_q == 3'd4) ? 3'd0 : idx_q + 3'd1;
        end_seen_q <= rx_last;
      end
      if (rx_state_q != DVSPC_RX_EMIT) begin
        e_q <= '0;
      end else if (!emit_stall) begin
        e_q <= e_q + 3'd1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rx_state_q == DVSPC_RX_HDR && rx_take) begin
      hq_q[idx_q] <= rx_data;
      if (idx_q == 3'd0) begin
        tok_q <= rx_token;
      end
    end
  end

  // sequence tracking and frame gating, only for streams that pass
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      keep_q <= 1'b0;
      started_q <= 1'b0;
      dropping_q <= 1'b0;
      last_seq_q <= '0;
      pkt_cnt_q <= '0;
      stream_break_irq_q <= 1'b0;
    end else begin
      stream_break_irq_q <= 1'b0;
      if (decide) begin
        keep_q <= rx_en && keep;
      end
      if (decide && rx_en && filt_ok && mode != DVSPC_MODE_HONLY) begin
        last_seq_q <= hq_q[3][23:20];
        pkt_cnt_q <= seq_new ? 5'd1 : pkt_cnt_q + 5'd1;
        stream_break_irq_q <= brk;
        if (sof) begin
          started_q <= 1'b1;
          dropping_q <= 1'b0;
        end else if (brk) begin
          dropping_q <= 1'b1;
        end
      end
    end
  end

  // header buffer for headers-only and split modes
  logic [31:0] hbuf_q [HBUF_DEPTH];
  logic [HA-1:0] hwr_q;
  logic [HA-1:0] hrd_q;
  logic [HW-1:0] hcnt_q;
  logic hovf_q;
  logic hpush;
  logic hpop;
  logic hfull;
  logic flush;

  assign flush = wr_rx_cfg && host_wdata[`DVSPC_RXC_FLUSH];
  assign hfull = hcnt_q == HW'(HBUF_DEPTH);
  assign hpush = rx_state_q == DVSPC_RX_EMIT && hcap_q && !emit_stall
    && !hfull && !hovf_q;
  assign hpop = rd_acc0 && hcnt_q != '0;

  always_ff @(posedge core_clk) begin
    if (hpush) begin
      hbuf_q[hwr_q] <= hword;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hcap_q <= 1'b0;
      hwr_q <= '0;
      hrd_q <= '0;
      hcnt_q <= '0;
      hovf_q <= 1'b0;
    end else begin
      if (decide) begin
        hcap_q <= rx_en && ((mode == DVSPC_MODE_HONLY && hdr_pkt)
          || (mode == DVSPC_MODE_SPLIT && keep));
      end
      // a word lost to a full buffer in the flush cycle still marks overflow
      if (rx_state_q == DVSPC_RX_EMIT && hcap_q && !emit_stall && hfull) begin
        hovf_q <= 1'b1;
      end else if (flush) begin
        hovf_q <= 1'b0;
      end
      if (flush) begin
        hwr_q <= '0;
        hrd_q <= '0;
        hcnt_q <= '0;
      end else begin
        if (hpush) begin
          hwr_q <= (hwr_q == HA'(HBUF_DEPTH - 1)) ? '0 : hwr_q + 1'b1;
        end
        if (hpop) begin
          hrd_q <= (hrd_q == HA'(HBUF_DEPTH - 1)) ? '0 : hrd_q + 1'b1;
        end
        hcnt_q <= hcnt_q + HW'(hpush) - HW'(hpop);
      end
    end
  end

  dvspc_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .in_valid(dq_push),
    .in_ready(dq_in_ready),
    .in_data(dq_in),
    .out_valid(dq_out_valid),
    .out_ready(dq_pop),
    .out_data(dq_out),
    .count(dq_cnt)
  );

  // in release mode the enable is gated outside; frame_in must be up too
  assign dq_pop = dq_out_valid && stream_port_write_enable
    && (!release_mode || frame_in);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stream_data_port_q <= '0;
      stream_port_data_available_q <= 1'b0;
      cell_available_q <= 1'b0;
      frame_out_q <= 1'b0;
    end else begin
      if (dq_pop) begin
        stream_data_port_q <= dq_out;
      end
      stream_port_data_available_q <= dq_cnt_next != '0;
      if (dq_push && dq_in_ready) begin
        cell_available_q <= 1'b1;
      end else if (dq_cnt_next == '0) begin
        cell_available_q <= 1'b0;
      end
      if (decide && rx_en && keep && mode != DVSPC_MODE_HONLY
          && hq_q[2][15:0] != `DVSPC_SYT_NONE) begin
        frame_out_q <= 1'b1;
      end else if (cell_available_q && dq_cnt_next == '0 && !dq_push) begin
        frame_out_q <= 1'b0;
      end
    end
  end

  // ---------------- transmit ----------------
  dvspc_tx_state_t tx_state_q;
  logic [2:0] k_q;
  logic first_sent_q;
  logic tx_ovr_q;
  logic tq_push;
  logic tq_in_ready;
  logic tq_out_valid;
  logic tq_pop;
  logic [32:0] tq_out;
  logic [CW-1:0] tq_cnt;
  logic adv;
  logic slot_on;
  logic dv_type;
  logic [CW-1:0] thresh;

  assign tq_push = wr_acc0 || wr_acc1;
  assign adv = !tx_valid_q || tx_ready;
  assign dv_type = tx_cfg_q[`DVSPC_TXC_TYPE_LO +: 2] == `DVSPC_TYPE_DV;
  assign slot_on = k_q < 3'd3
    ? tx_cfg_q[`DVSPC_TXC_HDR_INS] && (k_q == 3'd0 || dv_type)
    : tx_cfg_q[`DVSPC_TXC_DIF_INS];
  assign thresh = (CW'(tx_cfg_q[`DVSPC_TXC_DLY_SEL_LO +: 2]) + CW'(1))
    * CW'(`DVSPC_DLY_STEP);
  assign tq_pop = tx_state_q == DVSPC_TX_BODY && adv && tq_out_valid;

  dvspc_fifo #(.WIDTH(33), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .in_valid(tq_push),
    .in_ready(tq_in_ready),
    .in_data({wr_acc1, host_wdata}),
    .out_valid(tq_out_valid),
    .out_ready(tq_pop),
    .out_data(tq_out),
    .count(tq_cnt)
  );

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_state_q <= DVSPC_TX_IDLE;
      k_q <= '0;
      first_sent_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_data_q <= '0;
      tx_last_q <= 1'b0;
    end else begin
      if (adv) begin
        tx_valid_q <= 1'b0;
        tx_last_q <= 1'b0;
      end
      if (wr_tx_cfg) begin
        first_sent_q <= 1'b0;
      end
      case (tx_state_q)
        DVSPC_TX_IDLE: begin
          k_q <= '0;
          if (tq_out_valid && (first_sent_q || !tx_cfg_q[`DVSPC_TXC_DLY_EN]
              || tq_cnt >= thresh)) begin
            tx_state_q <= DVSPC_TX_HDR;
          end
        end
        DVSPC_TX_HDR: begin
          if (adv) begin
            if (slot_on) begin
              tx_valid_q <= 1'b1;
              tx_data_q <= txh_q[k_q];
            end
            k_q <= k_q + 3'd1;
            if (k_q == 3'd4) begin
              tx_state_q <= DVSPC_TX_BODY;
            end
          end
        end
        DVSPC_TX_BODY: begin
          if (tq_pop) begin
            tx_valid_q <= 1'b1;
            tx_data_q <= tq_out[31:0];
            tx_last_q <= tq_out[32];
            if (tq_out[32]) begin
              tx_state_q <= DVSPC_TX_IDLE;
              first_sent_q <= 1'b1;
            end
          end
        end
        default: tx_state_q <= DVSPC_TX_IDLE;
      endcase
    end
  end

  // host writes cannot stall, so a lost quadlet is flagged
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_ovr_q <= 1'b0;
    end else if (tq_push && !tq_in_ready) begin
      tx_ovr_q <= 1'b1;
    end else if (host_wr && host_addr == `DVSPC_OFS_STATUS) begin
      tx_ovr_q <= 1'b0;
    end
  end

  // ---------------- host read ----------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      host_rdata_q <= '0;
    end else if (host_rd) begin
      if (host_addr == `DVSPC_OFS_RX_CFG) begin
        host_rdata_q <= rx_cfg_q;
      end else if (host_addr == `DVSPC_OFS_FILT_A) begin
        host_rdata_q <= filt_a_q;
      end else if (host_addr == `DVSPC_OFS_FILT_B) begin
        host_rdata_q <= filt_b_q;
      end else if (host_addr == `DVSPC_OFS_STATUS) begin
        host_rdata_q <= 32'({3'b000, HW'(hcnt_q), 3'b000, 5'(dq_cnt),
          1'b0, started_q, tx_ovr_q, dropping_q, hovf_q, cell_available_q});
      end else if (host_addr == `DVSPC_OFS_TX_CFG) begin
        host_rdata_q <= tx_cfg_q;
      end else if (host_addr == `DVSPC_OFS_TX_H0) begin
        host_rdata_q <= txh_q[0];
      end else if (host_addr == `DVSPC_OFS_TX_H1) begin
        host_rdata_q <= txh_q[1];
      end else if (host_addr == `DVSPC_OFS_TX_H2) begin
        host_rdata_q <= txh_q[2];
      end else if (host_addr == `DVSPC_OFS_TX_H3) begin
        host_rdata_q <= txh_q[3];
      end else if (host_addr == `DVSPC_OFS_TX_H4) begin
        host_rdata_q <= txh_q[4];
      end else if (rd_acc0) begin
        host_rdata_q <= hcnt_q != '0 ? hbuf_q[hrd_q] : '0;
      end else begin
        host_rdata_q <= '0;
      end
    end
  end
endmodule

// file: verif/dvspc_checker.sv
module dvspc_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic rx_valid,
  input wire logic rx_ready_q,
  input wire logic stream_break_irq_q,
  input wire logic stream_port_write_enable,
  input wire logic [31:0] stream_data_port_q,
  input wire logic stream_port_data_available_q,
  input wire logic cell_available_q,
  input wire logic frame_out_q,
  input wire logic tx_valid_q,
  input wire logic [31:0] tx_data_q,
  input wire logic tx_last_q,
  input wire logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  sequence s_tx_stall;
    tx_valid_q && !tx_ready;
  endsequence
  property p_pop_hold;
    !stream_port_write_enable |=> $stable(stream_data_port_q);
  endproperty
  a_pop_hold: assert property (p_pop_hold)
    else $error("stream port moved without enable");
  property p_empty_hold;
    !stream_port_data_available_q |=> $stable(stream_data_port_q);
  endproperty
  a_empty_hold: assert property (p_empty_hold)
    else $error("stream port moved while empty");
  property p_cell_clear;
    $fell(cell_available_q) |-> !stream_port_data_available_q;
  endproperty
  a_cell_clear: assert property (p_cell_clear)
    else $error("cell available dropped with data left");
  property p_avail_fall;
    $fell(stream_port_data_available_q) |-> !cell_available_q;
  endproperty
  a_avail_fall: assert property (p_avail_fall)
    else $error("cell available kept on empty buffer");
  property p_frame_clear;
    $fell(frame_out_q) |-> !stream_port_data_available_q;
  endproperty
  a_frame_clear: assert property (p_frame_clear)
    else $error("frame out dropped with data left");
  property p_irq_pulse;
    stream_break_irq_q |=> !stream_break_irq_q;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("break interrupt longer than one cycle");
  // pulse lands one cycle after the fifth quadlet
  property p_irq_after;
    stream_break_irq_q |-> $past(rx_valid && rx_ready_q);
  endproperty
  a_irq_after: assert property (p_irq_after)
    else $error("break interrupt without a received quadlet");
  property p_tx_hold;
    s_tx_stall |=> tx_valid_q && $stable(tx_data_q) && $stable(tx_last_q);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx quadlet changed while stalled");
endmodule

bind dvspc_top dvspc_checker i_chk (.core_clk, .reset, .rx_valid, .rx_ready_q,
  .stream_break_irq_q, .stream_port_write_enable, .stream_data_port_q,
  .stream_port_data_available_q, .cell_available_q, .frame_out_q, .tx_valid_q,
  .tx_data_q, .tx_last_q, .tx_ready);

// file: verif/dvspc_codec_model.sv
module dvspc_codec_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic release_bit,
  input wire logic slow,
  input wire logic frame_out,
  input wire logic cell_avail,
  output logic codec_enable_out,
  output logic frame_in,
  output logic stream_port_write_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // slow codec pulls every other cycle
  always_ff @(negedge core_clk or posedge reset) begin
    if (reset) begin
      codec_enable_out <= 1'b0;
    end else begin
      codec_enable_out <= slow ? !codec_enable_out : 1'b1;
    end
  end
  always_ff @(negedge core_clk or posedge reset) begin
    if (reset) begin
      frame_in <= 1'b0;
    end else if (frame_out) begin
      frame_in <= 1'b1;
    end else if (!cell_avail) begin
      frame_in <= 1'b0;
    end
  end
  assign stream_port_write_enable = release_bit & codec_enable_out;
endmodule

// file: verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ISO = 32'h01e0_00a0;
  localparam logic [31:0] CIP0 = 32'h0078_0000;
  localparam logic [31:0] TOK = 32'h00ab_0000;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] host_addr = 8'h00;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [31:0] host_wdata = 32'h0000_0000;
  logic rx_valid = 1'b0;
  logic rx_last = 1'b0;
  logic [31:0] rx_data = 32'h0000_0000;
  logic [31:0] rx_token = TOK;
  logic tx_ready = 1'b0;
  logic rel = 1'b0;
  logic slow = 1'b0;
  logic pop_pend = 1'b0;
  logic [31:0] host_rdata_q, stream_data_port_q, tx_data_q, d;
  logic rx_ready_q, stream_break_irq_q, stream_port_write_enable, frame_in;
  logic stream_port_data_available_q, cell_available_q, frame_out_q;
  logic tx_valid_q, tx_last_q;
  logic [31:0] sq[$], tq[$];
  int num_errors = 0;
  int comparisons = 0;
  int irqs = 0;
  int last_at = -1;
  always #5 core_clk = ~core_clk;
  dvspc_top i_dut (.core_clk, .reset, .host_addr, .host_wr, .host_rd,
    .host_wdata, .host_rdata_q, .rx_valid, .rx_data, .rx_last, .rx_token,
    .rx_ready_q, .stream_break_irq_q, .stream_port_write_enable, .frame_in,
    .stream_data_port_q, .stream_port_data_available_q, .cell_available_q,
    .frame_out_q, .tx_valid_q, .tx_data_q, .tx_last_q, .tx_ready);
  dvspc_codec_model i_codec (.core_clk, .reset, .release_bit(rel), .slow,
    .frame_out(frame_out_q), .cell_avail(cell_available_q),
    .codec_enable_out(), .frame_in, .stream_port_write_enable);
  // link stalls every other cycle
  always @(negedge core_clk) tx_ready <= !tx_ready;
  always @(posedge core_clk) begin
    if (pop_pend) sq.push_back(stream_data_port_q);
    pop_pend <= stream_port_write_enable && stream_port_data_available_q
      && (!rel || frame_in);
    irqs <= irqs + stream_break_irq_q;
    if (tx_valid_q && tx_ready) tq.push_back(tx_data_q);
    if (tx_valid_q && tx_ready && tx_last_q) last_at <= tq.size();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    host_addr = a;
    host_wdata = v;
    host_wr = 1'b1;
    @(negedge core_clk);
    host_wr = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge core_clk);
    host_rd = 1'b0;
    @(negedge core_clk);
    v = host_rdata_q;
  endtask
  task automatic send_pkt(input logic [31:0] h0, input logic [15:0] syt,
      input int n);
    logic [31:0] q[$];
    q = '{ISO, CIP0, {16'h8000, syt}, h0, 32'h0000_00ff};
    for (int i = 0; i < n; i++) q.push_back(32'hd000_0000 + 32'(i));
    foreach (q[i]) begin
      rx_valid = 1'b1;
      rx_data = q[i];
      rx_last = (i == q.size() - 1);
      while (!rx_ready_q) @(negedge core_clk);
      @(negedge core_clk);
    end
    rx_valid = 1'b0;
    rx_last = 1'b0;
    repeat (12) @(negedge core_clk);
  endtask
  task automatic regs_test();
    logic [31:0] e[5];
    e = '{32'h0008_40a0, CIP0, 32'h8000_ffff, 32'h0000_0000, 32'h0000_0000};
    foreach (e[i]) begin
      rd(8'h14 + 8'(4 * i), d);
      check(d, e[i]);
    end
    wr(8'h24, 32'h1234_5678);
    rd(8'h24, d);
    check(d, 32'h1234_5678);
    wr(8'h24, 32'h0000_0000);
    rd(8'h40, d);
    check(d, 32'h0000_0000);
  endtask
  task automatic rx_test();
    logic [31:0] e[6];
    e = '{CIP0, 32'h8000_1234, 32'h0000_0000, 32'h0000_00ff, 32'hd000_0000,
      32'hd000_0001};
    wr(8'h00, 32'h0000_0009);
    send_pkt(32'h0000_0000, 16'h1234, 2);
    check(cell_available_q, 1'b1);
    check(stream_port_data_available_q, 1'b1);
    check(frame_out_q, 1'b1);
    check(sq.size(), 0);
    slow = 1'b1;
    wr(8'h00, 32'h0000_0109);
    rel = 1'b1;
    repeat (30) @(negedge core_clk);
    check(sq.size(), 6);
    foreach (e[i]) check(sq[i], e[i]);
    check(cell_available_q, 1'b0);
    rel = 1'b0;
  endtask
  task automatic break_test();
    int n0;
    wr(8'h00, 32'h0000_0039);
    send_pkt(32'h0000_0000, 16'hffff, 1);
    rd(8'h0c, d);
    check(d[10:6], 5'h03);
    n0 = irqs;
    send_pkt(32'h0020_0000, 16'hffff, 2);
    check(irqs - n0, 1);
    send_pkt(32'h0030_0000, 16'hffff, 2);
    rd(8'h0c, d);
    check(d[10:6], 5'h03);
  endtask
  task automatic honly_test();
    logic [31:0] e[6];
    e = '{TOK, ISO, CIP0, 32'h8000_ffff, 32'h0000_0000, 32'h0000_00ff};
    wr(8'h00, 32'h0000_0203);
    repeat (5) send_pkt(32'h0000_0000, 16'hffff, 1);
    rd(8'h0c, d);
    check(d[1], 1'b1);
    for (int i = 0; i < 24; i++) begin
      rd(8'h28, d);
      check(d, e[i % 6]);
    end
    send_pkt(32'h0000_0000, 16'hffff, 1);
    rd(8'h28, d);
    check(d, 32'h0000_0000);
    wr(8'h04, ISO ^ 32'h0000_0001);
    wr(8'h08, 32'h0000_0001);
    wr(8'h00, 32'h0000_0285);
    send_pkt(32'h0000_0000, 16'hffff, 1);
    rd(8'h28, d);
    check(d, ISO);
  endtask
  task automatic tx_test();
    logic [31:0] e[7];
    e = '{32'h0008_40a0, CIP0, 32'h8000_ffff, 32'h0000_0000, 32'h0000_0000,
      32'ha5a5_0001, 32'ha5a5_0002};
    wr(8'h10, 32'h0000_0027);
    wr(8'h28, e[5]);
    wr(8'h2c, e[6]);
    repeat (20) @(negedge core_clk);
    check(tq.size(), 0);
    wr(8'h10, 32'h0000_0023);
    repeat (40) @(negedge core_clk);
    check(tq.size(), 7);
    foreach (e[i]) check(tq[i], e[i]);
    check(last_at, 7);
  endtask
  task automatic conclude();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #100us;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    repeat (2) @(negedge core_clk);
    regs_test();
    rx_test();
    break_test();
    honly_test();
    tx_test();
    conclude();
  end
endmodule
